/* File: pkg/sipp_regs.vh */
// constants for the serial programming port
`ifndef SIPP_REGS_VH
`define SIPP_REGS_VH
`define SIPP_OP_ENABLE 8'hac
`define SIPP_OP_ECHO 8'h53
`define SIPP_OP_ERASE 8'h80
`define SIPP_OP_POLL 8'hf0
`define SIPP_OP_LD_EXT 8'h4d
`define SIPP_OP_LD_HI 8'h48
`define SIPP_OP_LD_LO 8'h40
`define SIPP_OP_LD_EE 8'hc1
`define SIPP_OP_RD_HI 8'h28
`define SIPP_OP_RD_LO 8'h20
`define SIPP_OP_WR_PAGE 8'h4c
`define SIPP_OP_RD_EE 8'ha0
`define SIPP_OP_WR_EE 8'hc0
`define SIPP_OP_WR_EEPG 8'hc2
`define SIPP_OP_RD_LOCK 8'h58
`define SIPP_OP_RD_FUSE 8'h50
`define SIPP_OP_RD_SIG 8'h30
`define SIPP_OP_RD_CAL 8'h38
`define SIPP_B2_EXT 8'h08
`define SIPP_B2_WR_LOCK 8'he0
`define SIPP_B2_WR_FUSE 8'ha0
`define SIPP_B2_WR_FHI 8'ha8
`define SIPP_B2_WR_FEXT 8'ha4
`define SIPP_FUSE_RESET 8'hff
`define SIPP_ERASED 8'hff
`define SIPP_CLK_MHZ 100
`define SIPP_FLASH_WAIT_US 4500
`define SIPP_EEPROM_WAIT_US 9000
`define SIPP_FLASH_WAIT_CYC (`SIPP_FLASH_WAIT_US * `SIPP_CLK_MHZ)
`define SIPP_EEPROM_WAIT_CYC (`SIPP_EEPROM_WAIT_US * `SIPP_CLK_MHZ)
`define SIPP_FIFO_DEPTH 16
`define SIPP_FIFO_AW 4
`define SIPP_CMD_W 32
`endif

/* File: hw/sipp_fifo.v */
// parameterised valid/ready word fifo
`timescale 1ns/1ps
module sipp_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_sys,
   input wire rst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] cnt_reg;
   wire push;
   wire pop;
   assign in_ready = (cnt_reg != DEPTH[AW:0]);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign out_data = mem_reg[rd_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
      if (rst) begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
         if (push & ~pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop & ~push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule // sipp_fifo

/* File: hw/sipp_port.v */
// serial in-system programming port, device side
`timescale 1ns/1ps
`include "sipp_regs.vh"
module sipp_port #(
   parameter FLASH_WAIT = `SIPP_FLASH_WAIT_CYC,
   parameter EEPROM_WAIT = `SIPP_EEPROM_WAIT_CYC
) (
   input wire clk_sys,
   input wire rst,
   input wire rst_pin_n,
   input wire sck,
   input wire mosi,
   output reg miso,
   output reg prog_mode,
   output reg prog_pending_flag,
   output reg [1:0] mem_op,
   output reg [15:0] mem_addr,
   output reg [7:0] mem_wdata,
   input wire [7:0] mem_rdata,
   output reg [7:0] fuse_low,
   output reg [7:0] fuse_high,
   output reg [7:0] fuse_ext,
   output reg [7:0] lock_bits,
   output reg [7:0] ee_wr_addr_hi
);
   // mem_op: 0 idle, 1 flash page commit, 2 eeprom byte write, 3 chip erase
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   reg [1:0] sck_sync_reg;
   reg [1:0] mosi_sync_reg;
   reg [1:0] rstn_sync_reg;
   reg sck_last_reg;
   wire sck_rise;
   wire sck_fall;
   always @(posedge clk_sys) begin
      if (rst) begin
         sck_sync_reg <= 2'b00;
         mosi_sync_reg <= 2'b00;
         rstn_sync_reg <= 2'b11;
         sck_last_reg <= 1'b0;
      end else begin
         sck_sync_reg <= {sck_sync_reg[0], sck};
         mosi_sync_reg <= {mosi_sync_reg[0], mosi};
         rstn_sync_reg <= {rstn_sync_reg[0], rst_pin_n};
         sck_last_reg <= sck_sync_reg[1];
      end
   end
   assign sck_rise = sck_sync_reg[1] & ~sck_last_reg;
   assign sck_fall = ~sck_sync_reg[1] & sck_last_reg;
   // ------------------------------------------------------------
   // shift engine
   // ------------------------------------------------------------
   reg [31:0] shift_reg;
   reg [4:0] bit_reg;
   reg [7:0] tx_reg;
   reg [7:0] tx_next;
   reg enabled_reg;
   reg cmd_valid_reg;
   wire cmd_ready;
   wire [31:0] cmd_data;
   wire cmd_valid;
   reg cmd_take;
   wire [31:0] shift_next;
   assign shift_next = {shift_reg[30:0], mosi_sync_reg[1]};
   // page buffers and stored extended address
   reg [7:0] flash_lo_reg [0:127];
   reg [7:0] flash_hi_reg [0:127];
   reg [7:0] ee_buf_reg [0:3];
   reg [7:0] ext_addr_reg;
   reg [31:0] wait_reg;
   wire busy;
   assign busy = (wait_reg != 32'h0) | cmd_valid;
   function [7:0] rd_cfg;
      input [31:0] w;
      begin
         rd_cfg = 8'hff;
         case (w[31:24])
            `SIPP_OP_POLL: rd_cfg = {7'h00, busy};
            `SIPP_OP_RD_LOCK: rd_cfg = (w[23:16] == `SIPP_B2_EXT) ? fuse_high : lock_bits;
            `SIPP_OP_RD_FUSE: rd_cfg = (w[23:16] == `SIPP_B2_EXT) ? fuse_ext : fuse_low;
            `SIPP_OP_RD_SIG: rd_cfg = mem_rdata;
            `SIPP_OP_RD_CAL: rd_cfg = mem_rdata;
            `SIPP_OP_RD_HI: rd_cfg = mem_rdata;
            `SIPP_OP_RD_LO: rd_cfg = mem_rdata;
            `SIPP_OP_RD_EE: rd_cfg = mem_rdata;
            default: rd_cfg = 8'hff;
         endcase
      end
   endfunction
   always @* begin
      tx_next = tx_reg;
      if (bit_reg == 5'd16) begin
         // second byte is the newest one in the shifter after sixteen bits
         tx_next = shift_reg[7:0];
      end else if (bit_reg == 5'd24) begin
         tx_next = rd_cfg({shift_reg[23:0], 8'h00});
      end else if (bit_reg == 5'd0) begin
         tx_next = 8'h00;
      end
   end
   // ------------------------------------------------------------
   // serial clock handling
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      cmd_take <= 1'b0;
      if (rst | rstn_sync_reg[1]) begin
         shift_reg <= 32'h0;
         bit_reg <= 5'd0;
         tx_reg <= 8'h00;
         miso <= 1'b0;
         enabled_reg <= 1'b0;
         prog_mode <= 1'b0;
      end else begin
         prog_mode <= enabled_reg;
         if (sck_rise) begin
            shift_reg <= shift_next;
            bit_reg <= bit_reg + 5'd1;
            if (bit_reg == 5'd31) begin
               cmd_take <= 1'b1;
               if (shift_next[31:16] == {`SIPP_OP_ENABLE, `SIPP_OP_ECHO}) begin
                  enabled_reg <= 1'b1;
               end
            end
         end
         if (sck_fall) begin
            if (bit_reg[2:0] == 3'd0) begin
               tx_reg <= {tx_next[6:0], 1'b0};
               miso <= tx_next[7];
            end else begin
               tx_reg <= {tx_reg[6:0], 1'b0};
               miso <= tx_reg[7];
            end
         end
      end
   end
   // read address presented to memory as soon as byte three lands
   always @(posedge clk_sys) begin
      if (rst) begin
         mem_addr <= 16'h0;
      end else if (sck_rise && bit_reg == 5'd23) begin
         case (shift_next[23:16])
            `SIPP_OP_RD_HI: mem_addr <= {shift_next[14:0], 1'b1};
            `SIPP_OP_RD_LO: mem_addr <= {shift_next[14:0], 1'b0};
            `SIPP_OP_RD_EE: mem_addr <= {6'h00, shift_next[9:0]};
            `SIPP_OP_RD_SIG: mem_addr <= {12'h000, shift_next[3:0]};
            default: mem_addr <= 16'h0;
         endcase
      end else if (cmd_valid && cmd_ready) begin
         case (cmd_data[31:24])
            `SIPP_OP_WR_PAGE: mem_addr <= {ext_addr_reg, cmd_data[23:16]};
            `SIPP_OP_WR_EE: mem_addr <= {6'h00, cmd_data[17:8]};
            `SIPP_OP_WR_EEPG: mem_addr <= {6'h00, cmd_data[17:10], 2'b00};
            default: mem_addr <= mem_addr;
         endcase
      end
   end
   // ------------------------------------------------------------
   // command queue; only words from the enabling word onward enter
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rst) begin
         cmd_valid_reg <= 1'b0;
      end else begin
         cmd_valid_reg <= cmd_take & enabled_reg;
      end
   end
   sipp_fifo #(
      .WIDTH(`SIPP_CMD_W),
      .DEPTH(`SIPP_FIFO_DEPTH),
      .AW(`SIPP_FIFO_AW)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst | rstn_sync_reg[1]),
      .in_data(shift_reg),
      .in_valid(cmd_valid_reg),
      .in_ready(),
      .out_data(cmd_data),
      .out_valid(cmd_valid),
      .out_ready(cmd_ready)
   );
   // executor stalls while a self-timed write runs
   assign cmd_ready = (wait_reg == 32'h0);
   // ------------------------------------------------------------
   // command executor
   // ------------------------------------------------------------
   integer i;
   always @(posedge clk_sys) begin
      if (rst) begin
         wait_reg <= 32'h0;
         ext_addr_reg <= 8'h00;
         mem_op <= 2'd0;
         mem_wdata <= 8'h00;
         prog_pending_flag <= 1'b0;
         fuse_low <= `SIPP_FUSE_RESET;
         fuse_high <= `SIPP_FUSE_RESET;
         fuse_ext <= `SIPP_FUSE_RESET;
         lock_bits <= `SIPP_FUSE_RESET;
         ee_wr_addr_hi <= 8'h00;
         for (i = 0; i < 128; i = i + 1) begin
            flash_lo_reg[i] <= `SIPP_ERASED;
            flash_hi_reg[i] <= `SIPP_ERASED;
         end
         for (i = 0; i < 4; i = i + 1) begin
            ee_buf_reg[i] <= `SIPP_ERASED;
         end
      end else begin
         mem_op <= 2'd0;
         prog_pending_flag <= busy;
         if (wait_reg != 32'h0) begin
            wait_reg <= wait_reg - 32'h1;
         end
         if (cmd_valid && cmd_ready) begin
            case (cmd_data[31:24])
               `SIPP_OP_LD_EXT: ext_addr_reg <= cmd_data[15:8];
               `SIPP_OP_LD_LO: flash_lo_reg[cmd_data[14:8]] <= cmd_data[7:0];
               `SIPP_OP_LD_HI: flash_hi_reg[cmd_data[14:8]] <= cmd_data[7:0];
               `SIPP_OP_LD_EE: ee_buf_reg[cmd_data[9:8]] <= cmd_data[7:0];
               `SIPP_OP_WR_PAGE: begin
                  mem_op <= 2'd1;
                  wait_reg <= FLASH_WAIT;
               end
               `SIPP_OP_WR_EE: begin
                  mem_op <= 2'd2; // erase-then-write is one self-timed op
                  mem_wdata <= cmd_data[7:0];
                  ee_wr_addr_hi <= {6'h00, cmd_data[17:16]};
                  wait_reg <= EEPROM_WAIT;
               end
               `SIPP_OP_WR_EEPG: begin
                  mem_op <= 2'd2;
                  mem_wdata <= ee_buf_reg[0];
                  wait_reg <= EEPROM_WAIT;
               end
               `SIPP_OP_ENABLE: begin
                  case (cmd_data[23:16])
                     `SIPP_OP_ERASE: begin
                        mem_op <= 2'd3;
                        wait_reg <= EEPROM_WAIT;
                        for (i = 0; i < 128; i = i + 1) begin
                           flash_lo_reg[i] <= `SIPP_ERASED;
                           flash_hi_reg[i] <= `SIPP_ERASED;
                        end
                     end
                     `SIPP_B2_WR_LOCK: lock_bits <= cmd_data[7:0] & lock_bits;
                     `SIPP_B2_WR_FUSE: fuse_low <= cmd_data[7:0];
                     `SIPP_B2_WR_FHI: fuse_high <= cmd_data[7:0];
                     `SIPP_B2_WR_FEXT: fuse_ext <= cmd_data[7:0];
                     default: ;
                  endcase
               end
               default: ;
            endcase
         end
      end
   end
endmodule // sipp_port

/* File: testbench/sipp_port_monitor.sv */
// assertions on the programming port pins
`timescale 1ns/1ps
module sipp_port_monitor #(
   parameter FLASH_WAIT = 20,
   parameter EEPROM_WAIT = 20
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic rst_pin_n,
   input wire logic sck,
   input wire logic miso,
   input wire logic prog_mode,
   input wire logic prog_pending_flag,
   input wire logic [1:0] mem_op,
   input wire logic [7:0] fuse_low,
   input wire logic [7:0] lock_bits
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // ----
   // busy length, long waits need a counter
   // ----
   int busy_reg;
   always @(posedge clk_sys) begin
      if (rst || !prog_pending_flag)
         busy_reg <= 0;
      else
         busy_reg <= busy_reg + 1;
   end
   sequence op_pulse_s;
      (mem_op != 2'h0) ##1 (mem_op == 2'h0);
   endsequence
   sequence exit_s;
      rst_pin_n [*6];
   endsequence
   miso_fall_a: assert property ($changed(miso) |-> !sck) else $error("miso moved with sck high");
   op_pulse_a: assert property ((mem_op != 2'h0) |-> op_pulse_s) else $error("mem_op held");
   op_busy_a: assert property ((mem_op != 2'h0) |-> ##[0:2] prog_pending_flag) else $error("no busy");
   op_mode_a: assert property ((mem_op != 2'h0) |-> prog_mode) else $error("op outside mode");
   exit_mode_a: assert property (exit_s |-> !prog_mode) else $error("mode kept");
   fuse_guard_a: assert property (!$stable(fuse_low) |-> $past(prog_mode)) else $error("fuse moved");
   lock_clear_a: assert property ((lock_bits & ~$past(lock_bits)) == 8'h00) else $error("lock set");
   busy_bound_a: assert property (busy_reg <= 2 * (FLASH_WAIT + EEPROM_WAIT)) else $error("busy stuck");
endmodule // sipp_port_monitor
bind sipp_port sipp_port_monitor #(.FLASH_WAIT(FLASH_WAIT), .EEPROM_WAIT(EEPROM_WAIT)) sipp_port_monitor_i (
   .clk_sys(clk_sys), .rst(rst), .rst_pin_n(rst_pin_n), .sck(sck), .miso(miso), .prog_mode(prog_mode),
   .prog_pending_flag(prog_pending_flag), .mem_op(mem_op), .fuse_low(fuse_low), .lock_bits(lock_bits));

/* File: testbench/sipp_prog_model.sv */
// programmer model driving the serial lines
`timescale 1ns/1ps
module sipp_prog_model #(
   parameter int START_NS = 300
) (
   output logic rst_pin_n,
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   initial begin
      rst_pin_n = 1'b0;
      sck = 1'b0;
      mosi = 1'b0;
   end
   task automatic begin_session();
      // one extra ns keeps every link edge off the system clock edges
      #(START_NS + 1);
   endtask
   task automatic set_rst(input logic v);
      rst_pin_n = v;
   endtask
   // 125 ns link period, phases far above the sampling minimum
   task automatic xfer(input logic [31:0] cmd, output logic [31:0] rx);
      for (int i = 31; i >= 0; i--) begin
         mosi = cmd[i];
         #62.5 sck = 1'b1;
         rx[i] = miso;
         #62.5 sck = 1'b0;
      end
      // released data line must not look stable
      #62.5 mosi = ~mosi;
   endtask
endmodule // sipp_prog_model

/* File: testbench/test_sipp_port.sv */
// self-checking bench for the serial programming port
`timescale 1ns/1ps
module test_sipp_port;
   logic clk_sys, rst, rst_pin_n, sck, mosi, miso, prog_mode, prog_pending_flag;
   logic [1:0] mem_op, seen_op;
   logic [15:0] mem_addr, seen_addr;
   logic [7:0] mem_wdata, mem_rdata, fuse_low, fuse_high, fuse_ext, lock_bits, ee_wr_addr_hi, seen_wd, lfsr_reg;
   logic [31:0] rx;
   int fail_count, tests_run, op_cnt;
   logic [7:0] wr_b2 [4] = '{8'he0, 8'ha0, 8'ha8, 8'ha4};
   logic [7:0] rd_b1 [4] = '{8'h58, 8'h50, 8'h58, 8'h50};
   logic [7:0] rd_b2 [4] = '{8'h00, 8'h00, 8'h08, 8'h08};
   logic [7:0] rd_op [5] = '{8'h28, 8'h20, 8'ha0, 8'h30, 8'h38};
   logic [7:0] cfg_v [4];
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   sipp_port #(.FLASH_WAIT(1000), .EEPROM_WAIT(1000)) sipp_port_i (.clk_sys(clk_sys), .rst(rst),
      .rst_pin_n(rst_pin_n), .sck(sck), .mosi(mosi), .miso(miso), .prog_mode(prog_mode),
      .prog_pending_flag(prog_pending_flag), .mem_op(mem_op), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext),
      .lock_bits(lock_bits), .ee_wr_addr_hi(ee_wr_addr_hi));
   sipp_prog_model sipp_prog_model_i (.rst_pin_n(rst_pin_n), .sck(sck), .mosi(mosi), .miso(miso));
   // ----
   // memory stand-in and op capture
   // ----
   function automatic logic [7:0] mem_exp(input logic [7:0] a);
      return a ^ 8'h5a;
   endfunction
   // low byte of the read address: flash reads put the byte select in bit 0
   function automatic logic [7:0] rd_addr(input logic [7:0] op, input logic [7:0] b3);
      case (op)
         8'h28: return {b3[6:0], 1'b1};
         8'h20: return {b3[6:0], 1'b0};
         8'h30: return {4'h0, b3[3:0]};
         8'h38: return 8'h00;
         default: return b3;
      endcase
   endfunction
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   always @(negedge clk_sys) mem_rdata <= mem_exp(mem_addr[7:0]);
   always @(posedge clk_sys) begin
      if (rst) begin
         op_cnt <= 0;
      end else if (mem_op != 2'h0) begin
         seen_op <= mem_op;
         seen_wd <= mem_wdata;
         seen_addr <= mem_addr;
         op_cnt <= op_cnt + 1;
      end
   end
   task automatic rnd();
      lfsr_reg = lfsr_next(lfsr_reg);
   endtask
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic send(input logic [31:0] c);
      sipp_prog_model_i.xfer(c, rx);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 20; i++) begin
         send(32'hf0000000);
         if (rx[0] === 1'b0)
            return;
      end
      check8("idle", 8'h00, rx[7:0]);
      summarize();
   endtask
   task automatic do_write(input logic [31:0] c, input logic [1:0] op);
      int n;
      n = op_cnt;
      send(c);
      check8("op count", 8'h01, 8'(op_cnt - n));
      check8("mem_op", {6'h0, op}, {6'h0, seen_op});
      send(32'hf0000000);
      check8("pending", 8'h01, {7'h0, rx[0]});
      check8("pending pin", 8'h01, {7'h0, prog_pending_flag});
      wait_idle();
      // queued polls must have drained once the poll reads idle
      check8("drained", 8'h00, {7'h0, prog_pending_flag});
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      rst = 1'b1;
      lfsr_reg = 8'h53;
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys) rst = 1'b0;
      check8("lock", 8'hff, lock_bits);
      sipp_prog_model_i.begin_session();
      send(32'haca00012);
      check8("fuse_low", 8'hff, fuse_low);
      send(32'hac530000);
      check8("echo", 8'h53, rx[15:8]);
      check8("mode", 8'h01, {7'h0, prog_mode});
      for (int k = 0; k < 4; k++) begin
         rnd();
         cfg_v[k] = lfsr_reg;
         send({8'hac, wr_b2[k], 8'h00, lfsr_reg});
         send({rd_b1[k], rd_b2[k], 16'h0});
         check8("config", lfsr_reg, rx[7:0]);
      end
      check8("lock pin", cfg_v[0], lock_bits);
      check8("fuse low pin", cfg_v[1], fuse_low);
      check8("fuse high pin", cfg_v[2], fuse_high);
      check8("fuse ext pin", cfg_v[3], fuse_ext);
      for (int k = 0; k < 5; k++) begin
         rnd();
         send({rd_op[k], 8'h00, lfsr_reg, 8'h00});
         check8("read", mem_exp(rd_addr(rd_op[k], lfsr_reg)), rx[7:0]);
      end
      send(32'h4d000100);
      send(32'h40000534);
      send(32'h48000512);
      do_write(32'h4c008000, 2'h1);
      check8("page addr hi", 8'h01, seen_addr[15:8]);
      check8("page addr lo", 8'h00, seen_addr[7:0]);
      rnd();
      do_write({8'hc0, 8'h01, 8'h07, lfsr_reg}, 2'h2);
      check8("wdata", lfsr_reg, seen_wd);
      check8("ee addr", 8'h07, seen_addr[7:0]);
      check8("ee addr hi", 8'h01, ee_wr_addr_hi);
      rnd();
      send({8'hc1, 16'h0000, lfsr_reg});
      do_write(32'hc2000700, 2'h2);
      check8("page byte", lfsr_reg, seen_wd);
      check8("ee page addr", 8'h04, seen_addr[7:0]);
      do_write(32'hac800000, 2'h3);
      sipp_prog_model_i.set_rst(1'b1);
      repeat (8) @(negedge clk_sys);
      check8("mode", 8'h00, {7'h0, prog_mode});
      summarize();
   end
endmodule // test_sipp_port
